// >>> rtl/acp_cfg.svh
/*
  timing constants for the converter port host controller.
  assumes a 125 MHz clk; counts derive from the ns figures.
*/
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH
`define ACP_CLK_PS          8000
`define ACP_T_CONV_NS       420
`define ACP_T_CSTART_NS     20
`define ACP_T_RD_CS_NS      30
`define ACP_T_RD_NS         30
`define ACP_T_ACCESS_NS     20
`define ACP_T_RELINQ_NS     20
`define ACP_T_ADDR_SU_NS    10
`define ACP_T_ADDR_HOLD_NS  15
`define ACP_T_CHSEL_NS      200
`define ACP_T_PERIOD_NS     500
`define ACP_T_PWR_INT_NS    25000
`define ACP_T_PWR_EXT_NS    1000
`define ACP_T_EOC_WAIT_NS   10
// slack for the done synchroniser beyond the conversion time
`define ACP_TMO_SLACK_CYC   8
// least times round up to whole cycles
`define ACP_CYC_UP(ns) (((ns) * 1000 + `ACP_CLK_PS - 1) / `ACP_CLK_PS)
`define ACP_CNT_W           16
`define ACP_ADDR_W          3
`define ACP_DATA_W          8
`endif

// >>> rtl/acp_pkg.sv
/*
  types for the converter port host controller.
  assumes acp_cfg.svh supplies the widths.
*/
`include "acp_cfg.svh"
package acp_pkg;
  typedef enum logic [6:0] {
    ACP_IDLE  = 7'h01,
    ACP_SETUP = 7'h02,
    ACP_START = 7'h04,
    ACP_CONV  = 7'h08,
    ACP_RDLO  = 7'h10,
    ACP_RDHI  = 7'h20,
    ACP_WAKE  = 7'h40
  } acp_state_t;
endpackage : acp_pkg

// >>> rtl/acp_timer.sv
/*
  down counter used for every pin timing interval of the host.
  assumes load and cen come from the same clock domain.
*/
`include "acp_cfg.svh"
module acp_timer (
  input  wire logic                   clk,   // system clock
  input  wire logic                   rst_n, // async reset, low
  input  wire logic                   cen,   // clock enable
  input  wire logic                   load,  // load a new count
  input  wire logic [`ACP_CNT_W-1:0]  value, // cycles to wait
  output logic                        done   // count exhausted
);
  logic [`ACP_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (cen) begin
      if (load) begin
        cnt_q <= value;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // done ignores load: callers load on done, so gating it would loop
  assign done = (cnt_q == '0);
endmodule : acp_timer

// >>> rtl/acp_host.sv
/*
  host controller that runs conversions on an eight-channel 8-bit
  converter through its clockless parallel pins and reads results.
  assumes the converter pins are asynchronous to clk; the done pin
  is synchronised, the byte bus is sampled late in the read strobe.
*/
`include "acp_cfg.svh"
// Functional notes
// - keep 30 ns from read strobe rising to next start falling.
// - wait 200 ns after a channel choice before starting it.
// - wake with internal reference takes 25 us after start rises.
// - wake with external reference takes 1 us after start rises.
// - start low pulse lasts at least 20 ns.
// - read strobe low pulse lasts at least 30 ns.
// - channel is chosen only by address during a read.
// - starts come no faster than 2 MSPS.
// - next channel stands on the address when read strobe falls.
module acp_host #(
  parameter int unsigned PWR_INT_CYC = `ACP_CYC_UP(`ACP_T_PWR_INT_NS)
) (
  input  wire logic                   clk,            // system clock
  input  wire logic                   rst_n,          // async reset, low
  input  wire logic                   cen,            // clock enable
  input  wire logic                   req_valid,      // convert request
  input  wire logic [`ACP_ADDR_W-1:0] req_chan,       // channel wanted
  input  wire logic                   req_sleep,      // power down after
  input  wire logic                   ext_ref,        // external reference
  output logic                        req_ready,      // request taken
  output logic                        rsp_valid,      // result pulse
  output logic [`ACP_DATA_W-1:0]      rsp_data,       // result code
  output logic [`ACP_ADDR_W-1:0]      rsp_chan,       // result channel
  output logic                        asleep,         // converter down
  output logic                        timeout_err,    // done never came
  output logic                        convert_start_n, // start strobe
  output logic                        port_select_n,  // chip select
  output logic                        read_strobe_n,  // read strobe
  output logic [`ACP_ADDR_W-1:0]      channel_addr,   // next channel
  input  wire logic                   conversion_done_n, // done pin
  input  wire logic [`ACP_DATA_W-1:0] sample_bus      // byte bus in
);
  localparam int unsigned CONV_CYC  = `ACP_CYC_UP(`ACP_T_CONV_NS);
  localparam int unsigned START_CYC = `ACP_CYC_UP(`ACP_T_CSTART_NS);
  localparam int unsigned GAP_CYC   = `ACP_CYC_UP(`ACP_T_RD_CS_NS);
  localparam int unsigned RD_CYC    = `ACP_CYC_UP(`ACP_T_RD_NS
                                      + `ACP_T_ACCESS_NS);
  localparam int unsigned RLQ_CYC   = `ACP_CYC_UP(`ACP_T_RELINQ_NS
                                      + `ACP_T_EOC_WAIT_NS);
  localparam int unsigned SU_CYC    = `ACP_CYC_UP(`ACP_T_ADDR_SU_NS);
  localparam int unsigned CHSEL_CYC = `ACP_CYC_UP(`ACP_T_CHSEL_NS);
  localparam int unsigned PER_CYC   = `ACP_CYC_UP(`ACP_T_PERIOD_NS);
  localparam int unsigned EXT_CYC   = `ACP_CYC_UP(`ACP_T_PWR_EXT_NS);
  // two synchroniser stages plus margin beyond the conversion time
  localparam int unsigned TMO_CYC   = CONV_CYC + `ACP_TMO_SLACK_CYC;

  function automatic logic [`ACP_CNT_W-1:0] cyc(input int unsigned n);
    return n[`ACP_CNT_W-1:0];
  endfunction : cyc

  acp_pkg::acp_state_t    state_q;
  logic [`ACP_ADDR_W-1:0] cur_chan_q;  // channel converting now
  logic [`ACP_ADDR_W-1:0] sel_chan_q;  // channel latched for next
  logic [`ACP_ADDR_W-1:0] dev_chan_q;  // channel the converter holds
  logic                   sleep_q;
  logic                   pend_q;      // request changed channel; clears as the read gap ends
  logic                   done_s1_q;
  logic                   done_s2_q;
  logic                   done_s3_q;
  logic                   done_fall;
  logic                   t_load;
  logic [`ACP_CNT_W-1:0]  t_val;
  logic                   t_done;
  logic                   p_load;
  logic                   p_done;

  acp_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .cen   (cen),
    .load  (t_load),
    .value (t_val),
    .done  (t_done)
  );

  // separate rate timer so sample spacing survives the read phase
  acp_timer u_rate (
    .clk   (clk),
    .rst_n (rst_n),
    .cen   (cen),
    .load  (p_load),
    .value (cyc(PER_CYC)),
    .done  (p_done)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_s1_q <= 1'b1;
      done_s2_q <= 1'b1;
      done_s3_q <= 1'b1;
    end else if (cen) begin
      done_s1_q <= conversion_done_n;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end
  // done pulse is 70 ns minimum, wide enough for two stages at 8 ns
  assign done_fall = done_s3_q && !done_s2_q;

  // next start waits for channel settle, spacing and read gap
  always_comb begin
    t_load = 1'b0;
    t_val  = '0;
    p_load = 1'b0;
    unique case (state_q)
      acp_pkg::ACP_IDLE: begin
        if (req_valid && !pend_q) begin
          t_load = 1'b1;
          t_val  = cyc(SU_CYC);
        end
      end
      acp_pkg::ACP_SETUP: begin
        if (t_done && p_done) begin
          t_load = 1'b1;
          t_val  = cyc(START_CYC);
          p_load = 1'b1;
        end
      end
      acp_pkg::ACP_START: begin
        if (t_done) begin
          t_load = 1'b1;
          t_val  = cyc(TMO_CYC);
        end
      end
      acp_pkg::ACP_CONV: begin
        if (done_fall || t_done) begin
          t_load = 1'b1;
          t_val  = cyc(RD_CYC);
        end
      end
      acp_pkg::ACP_RDLO: begin
        if (t_done) begin
          t_load = 1'b1;
          t_val  = cyc(GAP_CYC > CHSEL_CYC ?
                       GAP_CYC : CHSEL_CYC);
        end
      end
      acp_pkg::ACP_RDHI: begin
        if (t_done && sleep_q) begin
          t_load = 1'b1;
          t_val  = cyc(RLQ_CYC);
        end
      end
      acp_pkg::ACP_WAKE: begin
        if (t_done) begin
          t_load = 1'b1;
          t_val  = ext_ref ? cyc(EXT_CYC) : cyc(PWR_INT_CYC);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= acp_pkg::ACP_IDLE;
    end else if (cen) begin
      unique case (state_q)
        acp_pkg::ACP_IDLE:
          if (req_valid && !pend_q) state_q <= asleep ?
            acp_pkg::ACP_WAKE : acp_pkg::ACP_SETUP;
        acp_pkg::ACP_SETUP:
          if (t_done && p_done) state_q <= acp_pkg::ACP_START;
        acp_pkg::ACP_START:
          if (t_done) state_q <= acp_pkg::ACP_CONV;
        acp_pkg::ACP_CONV:
          if (done_fall || t_done) state_q <= acp_pkg::ACP_RDLO;
        acp_pkg::ACP_RDLO:
          if (t_done) state_q <= acp_pkg::ACP_RDHI;
        acp_pkg::ACP_RDHI:
          if (t_done) state_q <= acp_pkg::ACP_IDLE;
        acp_pkg::ACP_WAKE:
          if (t_done) state_q <= acp_pkg::ACP_SETUP;
      endcase
    end
  end

  // channel is carried only by the address pins during a read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_chan_q <= '0;
      dev_chan_q <= '0;
      cur_chan_q <= '0;
      sleep_q    <= 1'b0;
      pend_q     <= 1'b0;
    end else if (cen) begin
      if (state_q == acp_pkg::ACP_IDLE && req_valid && !pend_q) begin
        sel_chan_q <= req_chan;
        sleep_q    <= req_sleep;
        pend_q     <= (req_chan != sel_chan_q);
      end else if (state_q == acp_pkg::ACP_START) begin
        // a result belongs to the channel held before this read
        cur_chan_q <= dev_chan_q;
      end else if (state_q == acp_pkg::ACP_CONV
                   && (done_fall || t_done)) begin
        dev_chan_q <= sel_chan_q;
      end else if (state_q == acp_pkg::ACP_RDHI && t_done) begin
        pend_q     <= 1'b0;
      end
    end
  end

  // start pin: low pulse, held low through done when sleeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convert_start_n <= 1'b1;
    end else if (cen) begin
      if (state_q == acp_pkg::ACP_SETUP && t_done && p_done) begin
        convert_start_n <= 1'b0;
      end else if (state_q == acp_pkg::ACP_START && t_done && !sleep_q) begin
        convert_start_n <= 1'b1;
      end else if (state_q == acp_pkg::ACP_WAKE) begin
        convert_start_n <= 1'b1;
      end
    end
  end

  // sleep state takes sleep_q as the read gap ends and clears as the wake wait is loaded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep <= 1'b0;
    end else if (cen) begin
      if (state_q == acp_pkg::ACP_RDHI && t_done) begin
        asleep <= sleep_q;
      end else if (state_q == acp_pkg::ACP_WAKE && t_done) begin
        asleep <= 1'b0;
      end
    end
  end

  // read strobe and select, with address stable across the fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe_n <= 1'b1;
      port_select_n <= 1'b1;
      channel_addr  <= '0;
    end else if (cen) begin
      channel_addr <= sel_chan_q;
      if (state_q == acp_pkg::ACP_CONV && (done_fall || t_done)) begin
        read_strobe_n <= 1'b0;
        port_select_n <= 1'b0;
      end else if (state_q == acp_pkg::ACP_RDLO && t_done) begin
        read_strobe_n <= 1'b1;
        port_select_n <= 1'b1;
      end
    end
  end

  // sample at the end of the low strobe, after the access time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid   <= 1'b0;
      rsp_data    <= '0;
      rsp_chan    <= '0;
      timeout_err <= 1'b0;
    end else if (cen) begin
      rsp_valid <= 1'b0;
      if (state_q == acp_pkg::ACP_CONV && t_done && !done_fall) begin
        timeout_err <= 1'b1;
      end else if (req_valid && state_q == acp_pkg::ACP_IDLE) begin
        timeout_err <= 1'b0;
      end
      if (state_q == acp_pkg::ACP_RDLO && t_done) begin
        rsp_valid <= 1'b1;
        rsp_data  <= sample_bus;
        rsp_chan  <= cur_chan_q;
      end
    end
  end

  assign req_ready = cen && state_q == acp_pkg::ACP_IDLE && !pend_q;
endmodule : acp_host

// >>> tb/acp_host_asserts.sv
/* pin timing checker for acp_host.
   assumes a 125 MHz clk; bound to every acp_host instance. */
`include "acp_cfg.svh"
module acp_host_asserts #(
  parameter int unsigned PWR_INT_CYC = 20
) (
  input wire logic                   clk,               // clock
  input wire logic                   rst_n,             // reset, low
  input wire logic                   ext_ref,           // ext reference
  input wire logic                   rsp_valid,         // result pulse
  input wire logic                   convert_start_n,   // start pin
  input wire logic                   read_strobe_n,     // read pin
  input wire logic [`ACP_ADDR_W-1:0] channel_addr,      // address pins
  input wire logic                   conversion_done_n  // done pin
);
  logic [15:0] rd_age_q;
  logic [15:0] st_age_q;
  logic [15:0] wk_age_q;
  logic        slp_q;
  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat
  // ages start saturated so the first start after reset is legal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_age_q <= 16'hFFFF;
      st_age_q <= 16'hFFFF;
      wk_age_q <= 16'hFFFF;
    end else begin
      rd_age_q <= $fell(read_strobe_n) ? 16'h0000 : sat(rd_age_q);
      st_age_q <= $fell(convert_start_n) ? 16'h0000 : sat(st_age_q);
      wk_age_q <= ($rose(convert_start_n) && slp_q) ? 16'h0000 :
                  sat(wk_age_q);
    end
  end
  // mirrors the converter: start low as done rises means power-down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slp_q <= 1'b0;
    end else if ($rose(conversion_done_n)) begin
      slp_q <= !convert_start_n;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start_low; !convert_start_n [*3]; endsequence
  sequence s_read_low; !read_strobe_n [*4]; endsequence
  sequence s_addr_held; $stable(channel_addr) [*3]; endsequence
  sequence s_no_start; !$fell(convert_start_n) [*4]; endsequence
  property p_start_w; $fell(convert_start_n) |-> s_start_low; endproperty
  a_start_w: assert property (p_start_w)
    else $error("start pulse too short");
  property p_read_w; $fell(read_strobe_n) |-> s_read_low; endproperty
  a_read_w: assert property (p_read_w)
    else $error("read pulse too short");
  property p_rd_gap; $rose(read_strobe_n) |-> s_no_start; endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("start too soon after read");
  property p_chan; $fell(convert_start_n) |-> rd_age_q >= 16'h0018; endproperty
  a_chan: assert property (p_chan)
    else $error("start too soon after channel choice");
  property p_rate; $fell(convert_start_n) |-> st_age_q >= 16'h003E; endproperty
  a_rate: assert property (p_rate)
    else $error("starts too close together");
  property p_wake;
    $fell(convert_start_n) && slp_q |->
      wk_age_q >= (ext_ref ? 16'h007C : 16'(PWR_INT_CYC - 1));
  endproperty
  a_wake: assert property (p_wake)
    else $error("start before wake time");
  property p_addr;
    $fell(read_strobe_n) |->
      (channel_addr == $past(channel_addr, 2)) ##0 s_addr_held;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address moved around read fall");
  property p_result; $rose(read_strobe_n) |-> rsp_valid; endproperty
  a_result: assert property (p_result)
    else $error("no result after read");
endmodule : acp_host_asserts
bind acp_host acp_host_asserts #(.PWR_INT_CYC(PWR_INT_CYC))
  acp_host_asserts_inst (
  .clk, .rst_n, .ext_ref, .rsp_valid, .convert_start_n, .read_strobe_n,
  .channel_addr, .conversion_done_n);

// >>> tb/acp_adc_model.sv
/* behavioural converter at the far side of acp_host.
   assumes pins move in simulated time; it has no clock. */
`include "acp_cfg.svh"
module acp_adc_model #(
  parameter int INT_WAKE_NS = 25000
) (
  input  wire logic                   convert_start_n,   // start pin
  input  wire logic                   port_select_n,     // chip select
  input  wire logic                   read_strobe_n,     // read pin
  input  wire logic [`ACP_ADDR_W-1:0] channel_addr,      // address pins
  input  wire logic                   ext_ref,           // ext reference
  input  wire logic                   mute,              // never finish
  output logic                        conversion_done_n, // done pin
  output logic [`ACP_DATA_W-1:0]      sample_bus         // byte bus
);
  timeunit 1ns;
  timeprecision 100ps;
  int                     conv_ns = 300;
  logic [`ACP_ADDR_W-1:0] chan_q = 3'h0;
  logic [`ACP_ADDR_W-1:0] held_q = 3'h0;
  logic [`ACP_DATA_W-1:0] res_q = 8'h00;
  logic                   down_q = 1'b0;
  realtime                ready_at = 0;
  initial conversion_done_n = 1'b1;
  // released bus shows the inverse so stale data cannot pass
  assign #20 sample_bus = (!port_select_n && !read_strobe_n) ?
                          res_q : ~res_q;
  always @(negedge read_strobe_n) chan_q = channel_addr;
  always @(posedge convert_start_n) begin
    if (down_q) begin
      ready_at = $realtime + (ext_ref ? 1000 : INT_WAKE_NS);
      down_q = 1'b0;
    end
  end
  // a start before wake is over is lost, as on the real part
  always @(negedge convert_start_n) begin
    if (!mute && !down_q && $realtime >= ready_at) begin
      held_q = chan_q;
      #(conv_ns);
      res_q = {held_q, 5'h13};
      conversion_done_n = 1'b0;
      fork
        #100;
        @(posedge read_strobe_n) #5;
      join_any
      disable fork;
      conversion_done_n = 1'b1;
      down_q = !convert_start_n;
    end
  end
endmodule : acp_adc_model

// >>> tb/adc_conversion_port_control_bench.sv
/* self-checking bench for acp_host against a converter model.
   assumes the checker binds itself to acp_host. */
`include "acp_cfg.svh"
module adc_conversion_port_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cen = 1'b1;
  logic        req_valid = 1'b0;
  logic [2:0]  req_chan = 3'h0;
  logic        req_sleep = 1'b0;
  logic        ext_ref = 1'b1;
  logic        mute = 1'b0;
  logic        req_ready, rsp_valid, asleep, timeout_err;
  logic        convert_start_n, port_select_n, read_strobe_n;
  logic        conversion_done_n;
  logic [7:0]  rsp_data, sample_bus;
  logic [2:0]  rsp_chan, channel_addr, last_ch;
  logic [31:0] r;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          seed = 32'h8BF5;
  always #4 clk = ~clk;
  acp_host #(.PWR_INT_CYC(20)) acp_host_inst (.clk, .rst_n, .cen,
    .req_valid, .req_chan, .req_sleep, .ext_ref, .req_ready, .rsp_valid,
    .rsp_data, .rsp_chan, .asleep, .timeout_err, .convert_start_n,
    .port_select_n, .read_strobe_n, .channel_addr, .conversion_done_n,
    .sample_bus);
  acp_adc_model #(.INT_WAKE_NS(150)) acp_adc_model_inst (.convert_start_n,
    .port_select_n, .read_strobe_n, .channel_addr, .ext_ref, .mute,
    .conversion_done_n, .sample_bus);
  function automatic logic [7:0] exp_code(input logic [2:0] ch);
    return {ch, 5'h13};
  endfunction : exp_code
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // the conversion reports the channel latched by the previous read
  task automatic conv(input logic [2:0] ch, input logic slp, input logic bad);
    int i;
    i = 0;
    req_chan <= ch;
    req_sleep <= slp;
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1 && ++i < 3000);
    req_valid <= 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1 && ++i < 3000);
    check("rsp_valid", 8'(rsp_valid), 8'h01);
    if (bad) begin
      check("timeout_err", 8'(timeout_err), 8'h01);
    end else begin
      check("rsp_data", rsp_data, exp_code(last_ch));
      check("rsp_chan", 8'(rsp_chan), 8'(last_ch));
      check("timeout_err", 8'(timeout_err), 8'h00);
    end
    last_ch = ch;
    i = 0;
    // power state settles only once the read gap has run out
    do @(posedge clk); while (req_ready !== 1'b1 && ++i < 3000);
    check("req_ready", 8'(req_ready), 8'h01);
    check("asleep", 8'(asleep), 8'(slp));
  endtask : conv
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    last_ch = 3'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    conv(3'h0, 1'b0, 1'b0);
    conv(3'h7, 1'b0, 1'b0);
    conv(3'h7, 1'b1, 1'b0);
    conv(3'h2, 1'b0, 1'b0);
    ext_ref <= 1'b0;
    conv(3'h2, 1'b1, 1'b0);
    conv(3'h5, 1'b0, 1'b0);
    $display("test corner done");
    repeat (12) begin
      r = $random(seed);
      ext_ref <= r[4];
      acp_adc_model_inst.conv_ns = 100 + r[15:8];
      conv(r[2:0], r[3], 1'b0);
    end
    $display("test random done");
    mute = 1'b1;
    conv(3'h1, 1'b0, 1'b1);
    $display("test timeout done");
    test_done();
  end
  // whole run is some 2200 cycles; this cuts a hang
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule : adc_conversion_port_control_bench
